/* rtl/sapc_ctrl.sv */
/*
  sapc_ctrl: control of an 8-bit successive-approximation converter with
  threshold comparison, reached as an Avalon-MM slave with waitrequest.
  Assumes the comparator output arrives asynchronously and the analog
  front end follows the channel, tap code and sample-and-hold outputs.
*/
// Local design decision: the Avalon-MM register port.
module sapc_ctrl (
  // clock and control
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  input  wire logic                             ce,
  // register bus
  input  wire logic [sapc_pkg::AddrW-1:0]       address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [sapc_pkg::DataW-1:0]       writedata,
  input  wire logic [3:0]                       byteenable,
  output logic      [sapc_pkg::DataW-1:0]       readdata,
  output logic                                  waitrequest,
  // analog front end
  input  wire logic                             compIn,
  output sapc_pkg::sapc_front_t                 front,
  // interrupt controller
  output logic                                  convEndIrq
);
  sapc_pkg::sapc_ctrl_t st;
  sapc_pkg::sapc_ctrl_t nxt;

  logic                                         req;
  logic                                         accept;
  logic                                         wrMode;
  logic                                         wrChan;
  logic                                         wrCmpMode;
  logic                                         wrThresh;
  logic                                         abortW;
  logic                                         newStart;
  logic [3:0]                                   slotLen;
  logic                                         slotEnd;
  logic                                         sarLoad;
  logic                                         sarStep;
  logic                                         convEnd;
  logic [7:0]                                   sarApprox;
  logic [7:0]                                   sarMask;
  logic [7:0]                                   resolved;
  logic                                         cmpHit;
  logic                                         qualify;
  logic [7:0]                                   rdMux;

  // bus decode; a transfer completes on the edge where waitrequest is low
  always_comb begin
    req       = read | write;
    accept    = req & st.ack & ce;
    wrMode    = accept & write & byteenable[0] & sapc_pkg::hitIdx(address, sapc_pkg::IdxMode);
    wrChan    = accept & write & byteenable[0] & sapc_pkg::hitIdx(address, sapc_pkg::IdxChan);
    wrCmpMode = accept & write & byteenable[0]
                & sapc_pkg::hitIdx(address, sapc_pkg::IdxCmpMode);
    wrThresh  = accept & write & byteenable[0]
                & sapc_pkg::hitIdx(address, sapc_pkg::IdxThresh);
  end

  // read multiplexer; unmapped words read as zero
  always_comb begin
    rdMux = sapc_pkg::ByteZero;
    if (sapc_pkg::hitIdx(address, sapc_pkg::IdxMode)) begin
      rdMux = st.regs.mode;
    end
    if (sapc_pkg::hitIdx(address, sapc_pkg::IdxChan)) begin
      rdMux = st.regs.chan;
    end
    if (sapc_pkg::hitIdx(address, sapc_pkg::IdxCmpMode)) begin
      rdMux = st.regs.cmpMode;
    end
    if (sapc_pkg::hitIdx(address, sapc_pkg::IdxThresh)) begin
      rdMux = st.regs.thresh;
    end
    if (sapc_pkg::hitIdx(address, sapc_pkg::IdxResult)) begin
      rdMux = st.regs.result;
    end
  end

  // pacing and trial bookkeeping
  always_comb begin
    abortW   = wrMode | wrChan;
    newStart = wrMode ? writedata[sapc_pkg::StartBit] : st.regs.mode[sapc_pkg::StartBit];
    slotLen  = sapc_pkg::slotLen(st.regs.mode[sapc_pkg::TimeMsb:sapc_pkg::TimeLsb]);
    slotEnd  = st.tick == 4'(slotLen - 4'h1);
    sarLoad  = st.phase == sapc_pkg::PhSample && slotEnd && st.slot == sapc_pkg::SampleLast;
    sarStep  = st.phase == sapc_pkg::PhTrial && slotEnd;
    convEnd  = sarStep && sarMask[0];
    resolved = (sarApprox & ~sarMask) | (st.cmpSync2 ? sarMask : sapc_pkg::ByteZero);
  end

  // threshold qualification of a finished result
  always_comb begin
    if (st.regs.cmpMode[sapc_pkg::CmpDirBit]) begin
      cmpHit = resolved < st.regs.thresh;
    end else begin
      cmpHit = resolved >= st.regs.thresh;
    end
    qualify = !st.regs.cmpMode[sapc_pkg::CmpEnBit] || (st.firstDone && cmpHit);
  end

  // next state of the whole block
  always_comb begin
    nxt          = st;
    nxt.irq      = 1'b0;
    // comparator is asynchronous: two flip-flops before use
    nxt.cmpSync1 = compIn;
    nxt.cmpSync2 = st.cmpSync1;
    // one wait state per transfer
    nxt.ack      = req & ~st.ack;
    if (req & ~st.ack) begin
      nxt.rdata = rdMux;
    end
    if (wrMode) begin
      nxt.regs.mode = writedata[7:0];
      if (newStart && !st.regs.mode[sapc_pkg::StartBit]) begin
        nxt.firstDone = 1'b0;
      end
    end
    if (wrChan) begin
      nxt.regs.chan = writedata[7:0];
    end
    if (wrCmpMode) begin
      nxt.regs.cmpMode = writedata[7:0];
    end
    if (wrThresh) begin
      nxt.regs.thresh = writedata[7:0];
    end
    if (abortW) begin
      nxt.phase = newStart ? sapc_pkg::PhSample : sapc_pkg::PhIdle;
      nxt.slot  = '0;
      nxt.tick  = '0;
    end else if (st.phase != sapc_pkg::PhIdle) begin
      if (slotEnd) begin
        nxt.tick = '0;
        nxt.slot = st.slot + 4'h1;
      end else begin
        nxt.tick = st.tick + 4'h1;
      end
      if (sarLoad) begin
        nxt.phase = sapc_pkg::PhTrial;
      end
      if (convEnd) begin
        nxt.regs.result = resolved;
        nxt.irq         = qualify;
        nxt.firstDone   = 1'b1;
        nxt.phase       = sapc_pkg::PhSample;
        nxt.slot        = '0;
        nxt.tick        = '0;
      end
    end
  end

  // state register; ce low freezes everything
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st              <= '0;
      st.regs.mode    <= sapc_pkg::RegReset;
      st.regs.chan    <= sapc_pkg::RegReset;
      st.regs.cmpMode <= sapc_pkg::RegReset;
      st.regs.thresh  <= sapc_pkg::RegReset;
      st.regs.result  <= sapc_pkg::RegReset;
      st.phase        <= sapc_pkg::PhIdle;
    end else if (ce) begin
      st <= nxt;
    end
  end

  // trial bits live in the approximation register
  sapc_sar u_sar (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .clear   (abortW),
    .load    (sarLoad),
    .step    (sarStep),
    .verdict (st.cmpSync2),
    .approx  (sarApprox),
    .mask    (sarMask)
  );

  // outputs; waitrequest stays high while ce holds the block frozen
  assign waitrequest      = req & ~(st.ack & ce);
  assign readdata         = {24'h000000, st.rdata};
  assign convEndIrq       = st.irq;
  assign front.channel    = st.regs.chan[sapc_pkg::ChanMsb:0];
  assign front.sampleHold = st.phase == sapc_pkg::PhSample;
  assign front.tapCode    = sarApprox;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence storeS;
    ce && convEnd && !abortW;
  endsequence

  sequence clashS;
    ce && convEnd && abortW;
  endsequence

  irq_pulse_a: assert property (ce && convEndIrq |=> !convEndIrq)
    else $error("interrupt wider than one cycle");

  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    !reset_n |=> st.regs == '0)
    else $error("registers not cleared by reset");

  result_store_a: assert property (storeS |=> st.regs.result == $past(resolved))
    else $error("result not stored at conversion end");

  write_wins_a: assert property (clashS |=>
    st.regs.result == $past(st.regs.result) && !convEndIrq)
    else $error("store or interrupt despite register write");

  abort_restart_a: assert property (ce && abortW && newStart |=>
    st.phase == sapc_pkg::PhSample && st.slot == '0 && st.tick == '0)
    else $error("conversion not restarted after write");

  first_quiet_a: assert property (storeS ##0
    (st.regs.cmpMode[sapc_pkg::CmpEnBit] && !st.firstDone) |=> !convEndIrq)
    else $error("first compare result raised interrupt");

  cmp_dir_a: assert property (convEndIrq && $past(st.regs.cmpMode[sapc_pkg::CmpEnBit])
    |-> ($past(st.regs.cmpMode[sapc_pkg::CmpDirBit])
         ? st.regs.result < $past(st.regs.thresh)
         : st.regs.result >= $past(st.regs.thresh)))
    else $error("interrupt against compare direction");

  plain_irq_a: assert property (storeS ##0
    !st.regs.cmpMode[sapc_pkg::CmpEnBit] |=> convEndIrq)
    else $error("plain conversion missed its interrupt");

  run_on_a: assert property (storeS |=> st.phase == sapc_pkg::PhSample)
    else $error("conversions did not continue");

  slot_len_a: assert property (ce && st.phase != sapc_pkg::PhIdle && !abortW
    |-> st.tick < slotLen)
    else $error("slot counter ran past slot length");

  bus_ack_a: assert property (ce && req && !st.ack |=> !ce || !req || !waitrequest)
    else $error("transfer not acknowledged after one wait state");

endmodule // sapc_ctrl

/* rtl/sapc_pkg.sv */
/*
  sapc_pkg: constants, field layout, phase enumeration and carrier types of
  the successive-approximation converter control.
  Assumes one main clock at 20 MHz, an external comparator, tap ladder and
  sample-and-hold, and an Avalon-MM master for the registers.
*/
// Overview of operation
// - while the start bit is set, conversions run back to back until cleared
// - time field picks 144, 120, 96, 72, 60 or 48 cycles per conversion
// - channel field value 0 to 7 selects analog input 0 to 7
// - compare enable bit 7: plain conversion or threshold comparison
// - direction 0 fires at or above threshold, 1 fires below it
// - each result is compared with the full 8-bit threshold
// - approximation resolved MSB first, one trial bit per step
// - comparator verdict becomes the bit: 1 when input reaches the tap
// - after eight trials the value is stored and an interrupt may fire
// - mode or channel write aborts and restarts the conversion
// - reset clears result, mode, channel, compare mode and threshold
// - result equals integer part of input over reference times 256 plus 0.5
// - in compare mode, the first conversion after start raises no interrupt
// - a result read coinciding with a store returns the old value
// - mode or channel write beats a store: no store, no interrupt
package sapc_pkg;

  // bus shape
  localparam int unsigned AddrW = 18;
  localparam int unsigned DataW = 32;

  // register indexes; the byte address is four times the index
  localparam logic [15:0] IdxMode    = 16'hff98;
  localparam logic [15:0] IdxChan    = 16'hff99;
  localparam logic [15:0] IdxCmpMode = 16'hff9a;
  localparam logic [15:0] IdxThresh  = 16'hff9b;
  localparam logic [15:0] IdxResult  = 16'hff9c;
  localparam logic [7:0]  RegReset   = 8'h00;
  localparam logic [7:0]  ByteZero   = 8'h00;

  // field positions
  localparam int unsigned StartBit  = 7;
  localparam int unsigned TimeMsb   = 5;
  localparam int unsigned TimeLsb   = 3;
  localparam int unsigned ChanMsb   = 2;
  localparam int unsigned CmpEnBit  = 7;
  localparam int unsigned CmpDirBit = 6;

  // pacing: four sampling slots then eight trial slots
  localparam logic [3:0] SampleLast = 4'h3;
  localparam logic [7:0] SlotCount  = 8'h0c;
  localparam logic [7:0] TrialFirst = 8'h80;

  // conversion lengths in main clock cycles
  localparam logic [7:0] Cyc144 = 8'h90;
  localparam logic [7:0] Cyc120 = 8'h78;
  localparam logic [7:0] Cyc96  = 8'h60;
  localparam logic [7:0] Cyc72  = 8'h48;
  localparam logic [7:0] Cyc60  = 8'h3c;
  localparam logic [7:0] Cyc48  = 8'h30;

  // prohibited codes fall back to the slowest, safest setting
  function automatic logic [7:0] convCycles(input logic [2:0] code);
    case (code)
      3'h1:    return Cyc120;
      3'h2:    return Cyc96;
      3'h4:    return Cyc72;
      3'h5:    return Cyc60;
      3'h6:    return Cyc48;
      default: return Cyc144;
    endcase
  endfunction

  // cycles spent in one slot
  function automatic logic [3:0] slotLen(input logic [2:0] code);
    return 4'(convCycles(code) / SlotCount);
  endfunction

  // word address match for one register index
  function automatic logic hitIdx(input logic [AddrW-1:0] a, input logic [15:0] idx);
    return a[AddrW-1:2] == idx;
  endfunction

  typedef enum logic [1:0] {PhIdle, PhSample, PhTrial} sapc_phase_t;

  // analog front end steering
  typedef struct packed {
    logic       sampleHold;
    logic [2:0] channel;
    logic [7:0] tapCode;
  } sapc_front_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] chan;
    logic [7:0] cmpMode;
    logic [7:0] thresh;
    logic [7:0] result;
  } sapc_regs_t;

  typedef struct packed {
    sapc_regs_t  regs;
    sapc_phase_t phase;
    logic [3:0]  slot;
    logic [3:0]  tick;
    logic        firstDone;
    logic        ack;
    logic [7:0]  rdata;
    logic        irq;
    logic        cmpSync1;
    logic        cmpSync2;
  } sapc_ctrl_t;

  typedef struct packed {
    logic [7:0] approx;
    logic [7:0] mask;
  } sapc_sar_t;

endpackage

/* rtl/sapc_sar.sv */
/*
  sapc_sar: approximation register, resolved one trial bit per step.
  Assumes the caller synchronises the comparator verdict and paces steps.
*/
module sapc_sar (
  // clock and control
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // sequencing
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic       step,
  input  wire logic       verdict,
  // state seen by the caller
  output logic      [7:0] approx,
  output logic      [7:0] mask
);
  sapc_pkg::sapc_sar_t cur;
  sapc_pkg::sapc_sar_t nxt;

  // next value of the trial state
  always_comb begin
    nxt = cur;
    if (clear) begin
      nxt = '0;
    end else if (load) begin
      nxt.approx = sapc_pkg::TrialFirst;
      nxt.mask   = sapc_pkg::TrialFirst;
    end else if (step) begin
      if (!verdict) begin
        nxt.approx = cur.approx & ~cur.mask;
      end
      nxt.mask   = cur.mask >> 1;
      nxt.approx = nxt.approx | (cur.mask >> 1);
    end
  end

  // register the state; frozen while ce is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur <= '0;
    end else if (ce) begin
      cur <= nxt;
    end
  end

  assign approx = cur.approx;
  assign mask   = cur.mask;

  msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && load && !clear |=> approx == sapc_pkg::TrialFirst && mask == sapc_pkg::TrialFirst)
    else $error("trial did not start at the top bit");

endmodule // sapc_sar

/* verif/sapc_front_model.sv */
/*
  sapc_front_model: behavioural comparator, tap ladder and sample-and-hold.
  Assumes each channel level is given as the ideal code of its voltage and
  that the control steers channel, tap code and sampling from one clock.
*/
module sapc_front_model (
  // clock
  input  wire logic                  clk,
  // steering from the converter control
  input  wire sapc_pkg::sapc_front_t front,
  // per-channel input levels, eight codes packed low channel first
  input  wire logic [63:0]           levels,
  // comparator verdict
  output logic                       compIn
);
  logic [7:0] heldLevel = 8'h00;

  // held level tracks the selected input only while sampling
  always_ff @(posedge clk) begin
    if (front.sampleHold) begin
      heldLevel <= levels[front.channel*8 +: 8];
    end
  end

  // verdict high once the held level reaches the tap
  assign compIn = (heldLevel >= front.tapCode);
endmodule // sapc_front_model

/* verif/tb_sapc_ctrl.sv */
/*
  tb_sapc_ctrl: self-checking bench for the converter control.
  Assumes the front-end model answers at once and ce stays high except during the 20 frozen cycles of one test.
*/
module tb_sapc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;

  logic                         clk;
  logic                         resetN;
  logic                         ce;
  logic [sapc_pkg::AddrW-1:0]   address;
  logic                         read;
  logic                         write;
  logic [sapc_pkg::DataW-1:0]   writedata;
  logic [3:0]                   byteenable;
  logic [sapc_pkg::DataW-1:0]   readdata;
  logic                         waitrequest;
  logic                         compIn;
  sapc_pkg::sapc_front_t        front;
  logic                         convEndIrq;
  logic [63:0]                  levels = 64'ha53cc3017f80ff00;
  int                           nErrors = 0;
  int                           totalChecks = 0;
  logic [7:0]                   q;
  logic [7:0]                   old;
  int                           cnt;
  int                           k;

  // no code reaches the minimum at this clock; the ideal front end needs no settling
  localparam logic [2:0]  TimeCode [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  localparam logic [15:0] CycExp [6] = '{16'h0090, 16'h0078, 16'h0060,
                                         16'h0048, 16'h003c, 16'h0030};
  // dir, threshold and irq count over three conversions of a 0x80 input
  localparam logic [15:0] CmpCase [4] = '{16'h0802, 16'h0810, 16'h1812, 16'h1800};

  sapc_ctrl dut (
    .clk         (clk),
    .reset_n     (resetN),
    .ce          (ce),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .compIn      (compIn),
    .front       (front),
    .convEndIrq  (convEndIrq)
  );

  sapc_front_model analog (
    .clk    (clk),
    .front  (front),
    .levels (levels),
    .compIn (compIn)
  );

  // 20 MHz main clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finalReport;
    if (nErrors == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one Avalon transfer: held until waitrequest is seen low at a rising edge
  task automatic busXfer(input logic isWr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    address   <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    write     <= isWr;
    read      <= !isWr;
    // read data is taken at the very edge that ends the wait
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    busXfer(1'b1, idx, d);
  endtask

  // edges from the reference edge until the pulse shows; ends two edges later
  task automatic waitIrq(input int start);
    cnt = start;
    while (cnt < 400) begin
      @(negedge clk);
      if (convEndIrq === 1'b1) break;
      @(posedge clk);
      cnt++;
    end
    @(posedge clk);
    @(negedge clk);
    check(16'(convEndIrq), 16'h0000);
    @(posedge clk);
  endtask

  // hang guard
  initial begin
    repeat (12000) @(posedge clk);
    nErrors++;
    finalReport();
  end

  // main sequence
  initial begin
    resetN     = 1'b0;
    ce         = 1'b1;
    address    = '0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = '0;
    byteenable = 4'h1;
    repeat (4) @(posedge clk);
    resetN <= 1'b1;
    // reset values, unmapped place, read-only result
    for (int i = 0; i < 6; i++) begin
      busXfer(1'b0, sapc_pkg::IdxMode + 16'(i), 8'h00);
      check(16'(q), 16'h0000);
    end
    wr(sapc_pkg::IdxResult, 8'hff);
    busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
    check(16'(q), 16'h0000);
    // read back of the four writable registers
    for (int i = 0; i < 4; i++) begin
      wr(sapc_pkg::IdxMode + 16'(i), 8'h30 + 8'(i));
      busXfer(1'b0, sapc_pkg::IdxMode + 16'(i), 8'h00);
      check(16'(q), 16'(8'h30 + 8'(i)));
    end
    wr(sapc_pkg::IdxMode, 8'h00);
    wr(sapc_pkg::IdxCmpMode, 8'h00);
    // every channel and the six time codes in TimeCode (not 3 or 7): length, back to back, stored value
    for (int c = 0; c < 8; c++) begin
      wr(sapc_pkg::IdxChan, 8'(c));
      wr(sapc_pkg::IdxMode, {2'b10, TimeCode[c % 6], 3'b000});
      waitIrq(0);
      check(16'(cnt), CycExp[c % 6]);
      waitIrq(2);
      check(16'(cnt), CycExp[c % 6]);
      // first result ignored, second one read
      busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
      check(16'(q), 16'(levels[c*8 +: 8]));
      wr(sapc_pkg::IdxMode, 8'h00);
    end
    // stopped converter stays silent
    k = 0;
    repeat (200) begin
      @(negedge clk);
      if (convEndIrq === 1'b1) k++;
    end
    check(16'(k), 16'h0000);
    // frozen cycles stretch a conversion by exactly their number
    wr(sapc_pkg::IdxMode, 8'hb0);
    repeat (10) @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    waitIrq(30);
    check(16'(cnt), 16'h0030 + 16'h0014);
    wr(sapc_pkg::IdxMode, 8'h00);
    // mid-conversion channel write restarts the full count
    wr(sapc_pkg::IdxMode, 8'hb0);
    repeat (17) @(posedge clk);
    wr(sapc_pkg::IdxChan, 8'h00);
    waitIrq(0);
    check(16'(cnt), 16'h0030);
    wr(sapc_pkg::IdxMode, 8'h00);
    // write landing on the store edge suppresses store and pulse
    busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
    old = q;
    wr(sapc_pkg::IdxChan, 8'h05);
    wr(sapc_pkg::IdxMode, 8'hb0);
    repeat (45) @(posedge clk);
    wr(sapc_pkg::IdxChan, 8'h05);
    @(negedge clk);
    check(16'(convEndIrq), 16'h0000);
    busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
    check(16'(q), 16'(old));
    // read meeting the store edge of the restarted run gets the old value first
    repeat (43) @(posedge clk);
    busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
    check(16'(q), 16'(old));
    busXfer(1'b0, sapc_pkg::IdxResult, 8'h00);
    check(16'(q), 16'(levels[40 +: 8]));
    wr(sapc_pkg::IdxMode, 8'h00);
    // threshold comparison, both directions, on and just off the boundary
    wr(sapc_pkg::IdxChan, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(sapc_pkg::IdxThresh, CmpCase[i][11:4]);
      wr(sapc_pkg::IdxCmpMode, {1'b1, CmpCase[i][12], 6'h00});
      wr(sapc_pkg::IdxMode, 8'hb0);
      k = 0;
      repeat (150) begin
        @(negedge clk);
        if (convEndIrq === 1'b1) k++;
        @(posedge clk);
      end
      check(16'(k), 16'(CmpCase[i][3:0]));
      wr(sapc_pkg::IdxMode, 8'h00);
    end
    // reset in mid-run clears every register, result included
    wr(sapc_pkg::IdxMode, 8'hb0);
    repeat (20) @(posedge clk);
    resetN <= 1'b0;
    repeat (2) @(posedge clk);
    resetN <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      busXfer(1'b0, sapc_pkg::IdxMode + 16'(i), 8'h00);
      check(16'(q), 16'h0000);
    end
    finalReport();
  end
endmodule // tb_sapc_ctrl
